// file: verilog/tcc_pkg.sv
package tcc_pkg;
    // byte offsets of the registers on the slave port
    localparam logic [4:0] TCC_OFS_CTRL0 = 5'h00;
    localparam logic [4:0] TCC_OFS_CTRL1 = 5'h04;
    localparam logic [4:0] TCC_OFS_CH0_HIGH = 5'h08;
    localparam logic [4:0] TCC_OFS_CH0_LOW = 5'h0C;
    localparam logic [4:0] TCC_OFS_CH1_HIGH = 5'h10;
    localparam logic [4:0] TCC_OFS_CH1_LOW = 5'h14;
    // edge/level select codes
    localparam logic [1:0] TCC_ELS_OFF = 2'h0;
    localparam logic [1:0] TCC_ELS_RISE_TOGGLE = 2'h1;
    localparam logic [1:0] TCC_ELS_FALL_CLEAR = 2'h2;
    localparam logic [1:0] TCC_ELS_BOTH_SET = 2'h3;
    // channel control register layout, msb first
    typedef struct packed {
        logic channel_event_flag;     // bit 7, set by hardware
        logic reserved;               // bit 6, reads zero
        logic buffered_mode_select;   // bit 5, channel 0 only
        logic compare_mode_select;    // bit 4
        logic edge_level_select_hi;   // bit 3
        logic edge_level_select_lo;   // bit 2
        logic overflow_toggle_enable; // bit 1
        logic full_duty_force;        // bit 0
    } tcc_ctrl_s;
    localparam tcc_ctrl_s TCC_CTRL_RESET = 8'h00;
    // mask of bits software may write directly
    localparam logic [7:0] TCC_CTRL_WMASK = 8'h3F;
endpackage

// file: verilog/tcc_channels.sv
// How it works
// (RL1) select bits 00 releases pin to port
// (RL2) reset clears select bits of every channel
// (RL3) preset: mode X0 high, X1 low
// (RL4) capture on rise, fall or either edge
// (RL5) unbuffered compare toggles, clears or sets pin
// (RL6) buffered compare uses same pin actions
// (RL7) source holds pin stable two clocks first
// (RL8) overflow toggle in compare, cleared by reset
// (RL9) overflow action beats simultaneous compare
// (RL10) full duty force gives 100% output
// (RL11) full duty change acts next cycle
// (RL12) value registers hold capture or compare value
// (RL13) high byte read blocks capture until low
// (RL14) high byte write blocks compare until low
// (RL15) flag sets on capture edge or match
// (RL16) channel 0 buffered disables channel 1
// (RL17) software halts and clears counter first
// (RL18) buffered compare alternates values at overflow
`timescale 1ns/1ps
`default_nettype none
module tcc_channels
    import tcc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // avalon-mm slave
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // shared counter
    input wire logic [15:0] counter_value_in,
    input wire logic timer_tick_in,
    input wire logic counter_overflow_in,
    // channel pins
    input wire logic [1:0] channel_pin_in,
    output logic [1:0] channel_pin_out,
    output logic [1:0] channel_pin_oe_out,
    // event flags
    output logic [1:0] channel_event_flag_out
);
    ////////////////////////////////////////////////////////////////////////////
    // state
    tcc_ctrl_s ctrl_reg [2];        // channel control
    tcc_ctrl_s ctrl_next [2];
    logic [15:0] val_reg [2];       // channel values, no reset
    logic [15:0] val_next [2];
    logic [1:0] out_reg, out_next;  // pin output level
    logic [1:0] prev_reg, prev_next;    // pin last cycle, for edges
    logic [1:0] cap_blk_reg, cap_blk_next;  // capture held off
    logic [1:0] cmp_blk_reg, cmp_blk_next;  // compare held off
    logic [1:0] armed_reg, armed_next;  // flag seen set by a read
    logic [1:0] max_act_reg, max_act_next;  // full duty in this cycle
    logic buf_sel_reg, buf_sel_next;    // buffered: 1 = channel 1 value
    logic rvalid_reg, rvalid_next;  // read answer ready
    logic [7:0] rdata_reg, rdata_next;
    // per-channel decode, also seen by the checks
    logic [1:0] els_v [2];
    logic [1:0] en_v, capm_v, cmpm_v, hit_v, match_v, ovf_v;
    logic wr_en, rd_take;

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake: writes finish at once, reads wait one cycle
    assign avs_waitrequest_out = avs_read_in & ~rvalid_reg;
    assign avs_readdata_out = {24'h000000, rdata_reg};
    assign wr_en = avs_write_in & avs_byteenable_in[0];
    assign rd_take = avs_read_in & rvalid_reg;

    // pins and flags straight from state
    assign channel_pin_out = out_reg;
    assign channel_pin_oe_out = cmpm_v;     // capture and off leave pin undriven
    assign channel_event_flag_out = {ctrl_reg[1].channel_event_flag,
                                     ctrl_reg[0].channel_event_flag};

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic for channels and bus
    always_comb begin
        logic [15:0] act;
        logic [1:0] sel;
        logic rise, fall, flag_set, flag_clr;
        act = 16'h0000;
        sel = 2'h0;
        rise = 1'b0;
        fall = 1'b0;
        flag_set = 1'b0;
        flag_clr = 1'b0;
        ctrl_next = ctrl_reg;
        val_next = val_reg;
        out_next = out_reg;
        prev_next = channel_pin_in;
        cap_blk_next = cap_blk_reg;
        cmp_blk_next = cmp_blk_reg;
        armed_next = armed_reg;
        max_act_next = max_act_reg;
        buf_sel_next = buf_sel_reg;
        rvalid_next = avs_read_in & ~rvalid_reg;
        rdata_next = rdata_reg;
        // channel 1 is dead while channel 0 runs buffered
        en_v = {~ctrl_reg[0].buffered_mode_select, 1'b1}; // RL16
        // alternate the active compare value at each overflow
        if (ctrl_reg[0].buffered_mode_select) begin
            if (counter_overflow_in) begin
                buf_sel_next = ~buf_sel_reg; // RL18
            end
        end else begin
            buf_sel_next = 1'b0;
        end
        for (int ch = 0; ch < 2; ch++) begin
            // select bits 00 means channel is off the pin
            els_v[ch] = en_v[ch] ? {ctrl_reg[ch].edge_level_select_hi,
                                   ctrl_reg[ch].edge_level_select_lo} : TCC_ELS_OFF; // RL1
            capm_v[ch] = (els_v[ch] != TCC_ELS_OFF) & ~ctrl_reg[ch].buffered_mode_select
                         & ~ctrl_reg[ch].compare_mode_select;
            cmpm_v[ch] = (els_v[ch] != TCC_ELS_OFF) & ~capm_v[ch];
            // inputs are taken as synchronous, so no extra stages
            rise = channel_pin_in[ch] & ~prev_reg[ch];
            fall = ~channel_pin_in[ch] & prev_reg[ch];
            unique case (els_v[ch])
                TCC_ELS_RISE_TOGGLE: hit_v[ch] = rise; // RL4
                TCC_ELS_FALL_CLEAR: hit_v[ch] = fall; // RL4
                TCC_ELS_BOTH_SET: hit_v[ch] = rise | fall; // RL4
                TCC_ELS_OFF: hit_v[ch] = 1'b0;
            endcase
            hit_v[ch] = hit_v[ch] & capm_v[ch] & ~cap_blk_reg[ch]; // RL13
            // buffered channel 0 compares against either value
            act = (ch == 0 && ctrl_reg[0].buffered_mode_select && buf_sel_reg)
                  ? val_reg[1] : val_reg[ch]; // RL18
            match_v[ch] = cmpm_v[ch] & timer_tick_in & (counter_value_in == act)
                          & ~cmp_blk_reg[ch]; // RL14
            ovf_v[ch] = cmpm_v[ch] & ctrl_reg[ch].overflow_toggle_enable
                        & counter_overflow_in; // RL8
            // capture counter into the value register
            if (hit_v[ch]) begin
                val_next[ch] = counter_value_in; // RL12
            end
            // pin action; overflow first, then compare
            if (els_v[ch] == TCC_ELS_OFF) begin
                out_next[ch] = ~ctrl_reg[ch].compare_mode_select; // RL3
            end else if (ovf_v[ch]) begin
                out_next[ch] = max_act_reg[ch] ? 1'b1 : ~out_reg[ch]; // RL9 RL10
            end else if (match_v[ch] && !max_act_reg[ch]) begin
                unique case (els_v[ch])
                    TCC_ELS_RISE_TOGGLE: out_next[ch] = ~out_reg[ch]; // RL5 RL6
                    TCC_ELS_FALL_CLEAR: out_next[ch] = 1'b0; // RL5 RL6
                    TCC_ELS_BOTH_SET: out_next[ch] = 1'b1; // RL5 RL6
                    TCC_ELS_OFF: out_next[ch] = out_reg[ch];
                endcase
            end
            // full duty is sampled only at a cycle boundary
            if (counter_overflow_in) begin
                max_act_next[ch] = ctrl_reg[ch].full_duty_force
                                   & ctrl_reg[ch].overflow_toggle_enable; // RL11
            end
            // block flags leave with the mode
            if (!capm_v[ch]) begin
                cap_blk_next[ch] = 1'b0;
            end
            if (!cmpm_v[ch]) begin
                cmp_blk_next[ch] = 1'b0;
            end
            // bus side effects on this channel
            sel = ch[1:0];
            flag_set = hit_v[ch] | match_v[ch]; // RL15
            flag_clr = 1'b0;
            if (wr_en && avs_address_in == (sel[0] ? TCC_OFS_CTRL1 : TCC_OFS_CTRL0)
                && en_v[ch]) begin
                ctrl_next[ch] = (ctrl_reg[ch] & ~TCC_CTRL_WMASK)
                                | (avs_writedata_in[7:0] & TCC_CTRL_WMASK);
                // only channel 0 has the buffered select
                if (ch == 1) begin
                    ctrl_next[ch].buffered_mode_select = 1'b0;
                end
                // flag clears by read-while-set then write zero
                flag_clr = armed_reg[ch] & ~avs_writedata_in[7];
                armed_next[ch] = 1'b0;
            end
            if (wr_en && avs_address_in == (sel[0] ? TCC_OFS_CH1_HIGH : TCC_OFS_CH0_HIGH)) begin
                val_next[ch][15:8] = avs_writedata_in[7:0];
                cmp_blk_next[ch] = cmpm_v[ch]; // RL14
            end
            if (wr_en && avs_address_in == (sel[0] ? TCC_OFS_CH1_LOW : TCC_OFS_CH0_LOW)) begin
                val_next[ch][7:0] = avs_writedata_in[7:0];
                cmp_blk_next[ch] = 1'b0; // RL14
            end
            if (rd_take && avs_address_in == (sel[0] ? TCC_OFS_CTRL1 : TCC_OFS_CTRL0)
                && ctrl_reg[ch].channel_event_flag) begin
                armed_next[ch] = 1'b1;
            end
            if (rd_take && avs_address_in == (sel[0] ? TCC_OFS_CH1_HIGH : TCC_OFS_CH0_HIGH)) begin
                cap_blk_next[ch] = capm_v[ch]; // RL13
            end
            if (rd_take && avs_address_in == (sel[0] ? TCC_OFS_CH1_LOW : TCC_OFS_CH0_LOW)) begin
                cap_blk_next[ch] = 1'b0; // RL13
            end
            // a new event wins over a clear in the same cycle
            if (flag_set) begin
                ctrl_next[ch].channel_event_flag = 1'b1; // RL15
            end else if (flag_clr) begin
                ctrl_next[ch].channel_event_flag = 1'b0;
            end
        end
        // read data captured in the wait cycle
        if (avs_read_in && !rvalid_reg) begin
            unique case (avs_address_in)
                TCC_OFS_CTRL0: rdata_next = ctrl_reg[0];
                TCC_OFS_CTRL1: rdata_next = en_v[1] ? ctrl_reg[1] : 8'h00;
                TCC_OFS_CH0_HIGH: rdata_next = val_reg[0][15:8];
                TCC_OFS_CH0_LOW: rdata_next = val_reg[0][7:0];
                TCC_OFS_CH1_HIGH: rdata_next = val_reg[1][15:8];
                TCC_OFS_CH1_LOW: rdata_next = val_reg[1][7:0];
                default: rdata_next = 8'h00;    // unmapped reads zero
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers; channel values are deliberately not reset
    always_ff @(posedge clk_in) begin
        val_reg <= val_next;
        prev_reg <= prev_next;
        if (reset_in) begin
            ctrl_reg[0] <= TCC_CTRL_RESET; // RL2 RL8
            ctrl_reg[1] <= TCC_CTRL_RESET; // RL2 RL8
            out_reg <= 2'h3;
            cap_blk_reg <= 2'h0;
            cmp_blk_reg <= 2'h0;
            armed_reg <= 2'h0;
            max_act_reg <= 2'h0;
            buf_sel_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            ctrl_reg <= ctrl_next;
            out_reg <= out_next;
            cap_blk_reg <= cap_blk_next;
            cmp_blk_reg <= cmp_blk_next;
            armed_reg <= armed_next;
            max_act_reg <= max_act_next;
            buf_sel_reg <= buf_sel_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_off_pin; // RL1
        @(posedge clk_in) disable iff (reset_in)
        (els_v[0] == TCC_ELS_OFF) |-> !channel_pin_oe_out[0];
    endproperty
    a_off_pin: assert property (p_off_pin) else $error("pin driven while off"); // RL1

    property p_reset_sel; // RL2
        @(posedge clk_in) reset_in |=> (els_v[0] == TCC_ELS_OFF) && (els_v[1] == TCC_ELS_OFF);
    endproperty
    a_reset_sel: assert property (p_reset_sel) else $error("select bits not cleared"); // RL2

    property p_preset; // RL3
        @(posedge clk_in) disable iff (reset_in)
        (els_v[0] == TCC_ELS_OFF) |=> out_reg[0] == !$past(ctrl_reg[0].compare_mode_select);
    endproperty
    a_preset: assert property (p_preset) else $error("preset level wrong"); // RL3

    property p_capture; // RL4
        @(posedge clk_in) disable iff (reset_in)
        hit_v[1] |=> val_reg[1] == $past(counter_value_in) && ctrl_reg[1].channel_event_flag;
    endproperty
    a_capture: assert property (p_capture) else $error("capture lost"); // RL4

    property p_toggle; // RL5
        @(posedge clk_in) disable iff (reset_in)
        match_v[0] && !ovf_v[0] && !max_act_reg[0] && els_v[0] == TCC_ELS_RISE_TOGGLE
        |=> out_reg[0] != $past(out_reg[0]);
    endproperty
    a_toggle: assert property (p_toggle) else $error("compare toggle missing"); // RL5

    property p_ovf_first; // RL9
        @(posedge clk_in) disable iff (reset_in)
        ovf_v[0] && match_v[0] && !max_act_reg[0] |=> out_reg[0] != $past(out_reg[0]);
    endproperty
    a_ovf_first: assert property (p_ovf_first) else $error("overflow lost to compare"); // RL9

    property p_full_duty; // RL10
        @(posedge clk_in) disable iff (reset_in)
        ovf_v[0] && max_act_reg[0] |=> out_reg[0] ##1 out_reg[0] || !max_act_reg[0] || ovf_v[0];
    endproperty
    a_full_duty: assert property (p_full_duty) else $error("full duty not held"); // RL10

    // a held-off channel 1 must keep its captured value, whatever the pin does
    property p_cap_block; // RL13
        @(posedge clk_in) disable iff (reset_in)
        cap_blk_reg[1] && !wr_en |=> val_reg[1] == $past(val_reg[1]);
    endproperty
    a_cap_block: assert property (p_cap_block) else $error("capture while blocked"); // RL13

    property p_ch1_off; // RL16
        @(posedge clk_in) disable iff (reset_in)
        ctrl_reg[0].buffered_mode_select |-> !channel_pin_oe_out[1] && !match_v[1];
    endproperty
    a_ch1_off: assert property (p_ch1_off) else $error("channel 1 active in buffered"); // RL16
endmodule
`default_nettype wire

// file: sim/tcc_pin_source.sv
`timescale 1ns/1ps
`default_nettype none
// far-side source on the channel pins: drives a pin whenever the channel does not
module tcc_pin_source (
    // channel side
    input wire logic [1:0] pin_out_in,
    input wire logic [1:0] pin_oe_in,
    // level the source wants to put on each pin
    input wire logic [1:0] level_in,
    // resolved wire level, fed back to the channel inputs
    output logic [1:0] pin_level_out
);
    ////////////////////////////////////////////////////////////////////////////////
    // wire resolution: the channel driver wins while enabled, else the source shows
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pin_level_out[i] = pin_oe_in[i] ? pin_out_in[i] : level_in[i];
        end
    end
endmodule
`default_nettype wire

// file: sim/tb_timer_channel_capture_compare.sv
`timescale 1ns/1ps
`default_nettype none
module tb_timer_channel_capture_compare
    import tcc_pkg::*;
;
    // bench stimulus, all given a value at time zero
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] adr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [7:0] wd = 8'h00;
    logic [3:0] be = 4'h1;
    logic [15:0] cnt = 16'h0000;
    logic tick = 1'b0;
    logic ovf = 1'b0;
    logic [1:0] src = 2'h0;
    // design outputs and resolved pins
    logic [31:0] rdata;
    logic wreq;
    logic [1:0] pin_lvl;
    logic [1:0] pin_o;
    logic [1:0] pin_oe;
    logic [1:0] flag;
    // bookkeeping
    int num_errors = 0;
    int checked = 0;
    logic [31:0] q;
    logic e;

    always #25 clk = ~clk;

    tcc_channels dut (.clk_in(clk), .reset_in(rst), .avs_address_in(adr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in({24'h000000, wd}), .avs_byteenable_in(be),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .counter_value_in(cnt),
        .timer_tick_in(tick), .counter_overflow_in(ovf), .channel_pin_in(pin_lvl),
        .channel_pin_out(pin_o), .channel_pin_oe_out(pin_oe), .channel_event_flag_out(flag));

    tcc_pin_source src_model (.pin_out_in(pin_o), .pin_oe_in(pin_oe), .level_in(src),
        .pin_level_out(pin_lvl));

    ////////////////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one avalon access; waitrequest and read data taken at the same rising edge
    task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
        adr <= a;
        rd <= !w;
        wr <= w;
        wd <= d;
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        // one idle edge so strobes never toggle twice in one step
        @(posedge clk);
    endtask
    task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
        bus(a, 1'b0, 8'h00);
        chk(q, {24'h000000, exp});
    endtask
    // one counter cycle, result landed after the second edge
    task automatic cyc(input logic [15:0] c, input logic t, input logic o);
        cnt <= c;
        tick <= t;
        ovf <= o;
        @(posedge clk);
        tick <= 1'b0;
        ovf <= 1'b0;
        @(posedge clk);
    endtask
    // source moves channel 1 pin, counter held, room for the capture to land
    task automatic edge_at(input logic l, input logic [15:0] c);
        cnt <= c;
        src[1] <= l;
        repeat (4) @(posedge clk);
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(pin_oe, 2'h0);
        chk(pin_o, 2'h3);
        chk(flag, 2'h0);
        rchk(TCC_OFS_CTRL0, 8'h00);
        rchk(TCC_OFS_CTRL1, 8'h00);
        rchk(5'h18, 8'h00);
        // write with lane 0 off must not land
        be <= 4'h0;
        bus(TCC_OFS_CTRL0, 1'b1, 8'h10);
        be <= 4'h1;
        rchk(TCC_OFS_CTRL0, 8'h00);
        // preset low, pin still released
        bus(TCC_OFS_CTRL0, 1'b1, 8'h10);
        // preset level is registered one edge after the control write
        @(posedge clk);
        chk({pin_oe[0], pin_o[0]}, 2'h0);
        bus(TCC_OFS_CH0_HIGH, 1'b1, 8'h12);
        bus(TCC_OFS_CH0_LOW, 1'b1, 8'h34);
        // toggle, clear, set on match
        e = 1'b0;
        for (int k = 1; k < 4; k++) begin
            bus(TCC_OFS_CTRL0, 1'b1, 8'h10 | 8'(k << 2));
            chk(pin_oe[0], 1'b1);
            cyc(16'h1234, 1'b1, 1'b0);
            e = (k == 1) ? !e : (k == 3);
            chk(pin_o[0], e);
        end
        chk(flag[0], 1'b1);
        // half-written compare value holds compares off
        bus(TCC_OFS_CTRL0, 1'b1, 8'h18);
        bus(TCC_OFS_CH0_HIGH, 1'b1, 8'h12);
        cyc(16'h1234, 1'b1, 1'b0);
        chk(pin_o[0], 1'b1);
        bus(TCC_OFS_CH0_LOW, 1'b1, 8'h34);
        cyc(16'h1234, 1'b1, 1'b0);
        chk(pin_o[0], 1'b0);
        // overflow toggle, and overflow beating a set on the same cycle
        bus(TCC_OFS_CTRL0, 1'b1, 8'h1E);
        cyc(16'h0000, 1'b0, 1'b1);
        chk(pin_o[0], 1'b1);
        cyc(16'h1234, 1'b1, 1'b1);
        chk(pin_o[0], 1'b0);
        // full duty: forced from next overflow until the cycle after clearing
        bus(TCC_OFS_CTRL0, 1'b1, 8'h1B);
        cyc(16'h0000, 1'b0, 1'b1);
        cyc(16'h1234, 1'b1, 1'b0);
        chk(pin_o[0], 1'b1);
        bus(TCC_OFS_CTRL0, 1'b1, 8'h1A);
        cyc(16'h1234, 1'b1, 1'b0);
        chk(pin_o[0], 1'b1);
        cyc(16'h0000, 1'b0, 1'b1);
        cyc(16'h1234, 1'b1, 1'b0);
        chk(pin_o[0], 1'b0);
        // capture on channel 1, pin held still before enabling
        src <= 2'h0;
        repeat (3) @(posedge clk);
        for (int k = 1; k < 4; k++) begin
            bus(TCC_OFS_CTRL1, 1'b1, 8'(k << 2));
            edge_at(1'b1, 16'hA100 + 16'(k));
            edge_at(1'b0, 16'hB200 + 16'(k));
            rchk(TCC_OFS_CH1_HIGH, (k == 1) ? 8'hA1 : 8'hB2);
            rchk(TCC_OFS_CH1_LOW, 8'(k));
        end
        chk(flag[1], 1'b1);
        // high byte read freezes the captured value until low is read
        rchk(TCC_OFS_CH1_HIGH, 8'hB2);
        edge_at(1'b1, 16'hC0DE);
        rchk(TCC_OFS_CH1_LOW, 8'h03);
        edge_at(1'b0, 16'hD00D);
        rchk(TCC_OFS_CH1_HIGH, 8'hD0);
        rchk(TCC_OFS_CH1_LOW, 8'h0D);
        // buffered: channel 1 gives way, values alternate per overflow
        bus(TCC_OFS_CTRL1, 1'b1, 8'h14);
        chk(pin_oe[1], 1'b1);
        bus(TCC_OFS_CH1_HIGH, 1'b1, 8'h22);
        bus(TCC_OFS_CH1_LOW, 1'b1, 8'h22);
        bus(TCC_OFS_CH0_HIGH, 1'b1, 8'h11);
        bus(TCC_OFS_CH0_LOW, 1'b1, 8'h11);
        // counter idle (no tick, no overflow) across the mode change
        bus(TCC_OFS_CTRL0, 1'b1, 8'h24);
        chk(pin_oe[1], 1'b0);
        rchk(TCC_OFS_CTRL1, 8'h00);
        // pin was left low by the last clear; value 0 is active first
        cyc(16'h1111, 1'b1, 1'b0);
        chk(pin_o[0], 1'b1);
        cyc(16'h2222, 1'b1, 1'b0);
        chk(pin_o[0], 1'b1);
        cyc(16'h0000, 1'b0, 1'b1);
        cyc(16'h1111, 1'b1, 1'b0);
        chk(pin_o[0], 1'b1);
        cyc(16'h2222, 1'b1, 1'b0);
        chk(pin_o[0], 1'b0);
        print_verdict();
    end

    // watchdog, far beyond the fewer than 200 cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
